// *** design/bdmm_map.sv ***
// Banked data memory decoder, core register bank and general-purpose RAM.
`timescale 1ns/1ps
module bdmm_map
	import bdmm_pkg::*;
#(
	parameter int PORT_A_WIDTH = PORT_A_BITS
) (
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           rst_power_up,
	// Core register access
	input  wire bdmm_access_s   acc,
	output logic [7:0]          rdata,
	output logic                rvalid,
	// Core datapath updates
	input  wire bdmm_flag_upd_s flag_upd,
	input  wire logic           pc_step,
	input  wire logic [7:0]     pc_low_next,
	input  wire logic           timer_tick,
	// Register views for the core and the pins
	output logic                pc_write,
	output logic [12:0]         pc_load_value,
	output logic [7:0]          flags,
	output logic [7:0]          port_a_out,
	output logic [7:0]          port_b_out
);

	// The warm reset keeps the top port A bit and clears the rest, so the
	// latch needs at least two bits.
	if (PORT_A_WIDTH < 2 || PORT_A_WIDTH > 8) begin : g_bad_width
		$error("PORT_A_WIDTH must lie between 2 and 8.");
	end

	logic [7:0]                timer_q,   timer_d;
	logic [7:0]                pcl_q,     pcl_d;
	logic [7:0]                flags_q,   flags_d;
	logic [7:0]                ptr_q,     ptr_d;
	logic [PORT_A_WIDTH-1:0]   port_a_pins_q,   port_a_pins_d;
	logic [7:0]                port_b_pins_q,   port_b_pins_d;
	logic [PC_HI_BITS-1:0]     pch_q,     pch_d;
	logic [7:0]                rdata_q,   rdata_d;
	logic                      rvalid_q,  rvalid_d;
	logic                      pcw_q,     pcw_d;
	logic [12:0]               pcv_q,     pcv_d;
	logic [7:0]                gpr_mem [GPR_WORDS];

	logic [7:0]                full_addr;
	logic                      is_indirect;
	bdmm_target_e              tgt;
	logic [6:0]                ram_idx;
	logic [7:0]                rd_mux;
	logic                      chk_ok_q,   chk_ok_d;
	logic [7:0]                chk_addr_q, chk_addr_d;
	logic [7:0]                chk_data_q, chk_data_d;

	// The direct address gets the bank bit on top; offset 00h takes the
	// pointer's full address instead.
	always_comb begin
		is_indirect = (acc.addr == OFF_INDIRECT_DATA);
		if (is_indirect) begin
			full_addr = ptr_q;
		end else begin
			full_addr = {flags_q[FLG_BANK_SEL], acc.addr};
		end
	end

	// Decode of the full address. A pointer aimed at 00h or 80h finds no
	// register, so the indirect port never loops on itself.
	always_comb begin
		tgt     = TGT_NONE;
		ram_idx = 7'h00;
		if (full_addr >= GPR0_FIRST && full_addr <= GPR0_LAST) begin
			tgt     = TGT_RAM;
			ram_idx = 7'(full_addr - GPR0_FIRST);
		end else if (full_addr >= GPR1_FIRST && full_addr <= GPR1_LAST) begin
			tgt     = TGT_RAM;
			ram_idx = 7'(GPR1_BASE + 7'(full_addr - GPR1_FIRST));
		end else if (full_addr >= ALIAS_FIRST) begin
			tgt     = TGT_RAM;
			ram_idx = 7'((full_addr & ALIAS_MASK) - GPR0_FIRST);
		end else begin
			// PCL, flags, pointer and high latch sit at the same low offset in either bank; timer and ports only in bank 0.
			case (full_addr[6:0])
				OFF_PC_LOW_BYTE:   tgt = TGT_PCL;
				OFF_CORE_FLAGS:    tgt = TGT_FLAGS;
				OFF_IND_POINTER:   tgt = TGT_POINTER;
				OFF_PC_HIGH_LATCH: tgt = TGT_PCH;
				OFF_TIMER_COUNT:   tgt = full_addr[7] ? TGT_NONE : TGT_TIMER;
				OFF_PORT_A_PINS:   tgt = full_addr[7] ? TGT_NONE : TGT_PORT_A;
				OFF_PORT_B_PINS:   tgt = full_addr[7] ? TGT_NONE : TGT_PORT_B;
				// 07h-09h and all other offsets decode to nothing.
				default:           tgt = TGT_NONE;
			endcase
		end
	end

	// Read multiplexer; unmapped space and missing bits return zero.
	always_comb begin
		case (tgt)
			TGT_TIMER:   rd_mux = timer_q;
			TGT_PCL:     rd_mux = pcl_q;
			TGT_FLAGS:   rd_mux = flags_q;
			TGT_POINTER: rd_mux = ptr_q;
			TGT_PORT_A:  rd_mux = 8'(port_a_pins_q);
			TGT_PORT_B:  rd_mux = port_b_pins_q;
			TGT_PCH:     rd_mux = 8'(pch_q);
			TGT_RAM:     rd_mux = gpr_mem[ram_idx];
			default:     rd_mux = READ_ZERO;
		endcase
	end

	// Next values of the register bank.
	always_comb begin
		timer_d  = timer_q;
		pcl_d    = pcl_q;
		flags_d  = flags_q;
		ptr_d    = ptr_q;
		port_a_pins_d  = port_a_pins_q;
		port_b_pins_d  = port_b_pins_q;
		pch_d    = pch_q;
		pcw_d    = 1'b0;
		pcv_d    = pcv_q;
		rvalid_d = acc.rd;
		rdata_d  = acc.rd ? rd_mux : rdata_q;
		if (timer_tick) begin
			timer_d = timer_q + 8'h01;
		end
		if (pc_step) begin
			pcl_d = pc_low_next;
		end
		if (flag_upd.pwr_we) begin
			flags_d[FLG_TIMEOUT] = flag_upd.timeout;
			flags_d[FLG_PWRDOWN] = flag_upd.powerdown;
		end
		// Register writes override timer tick and pc step updates of the same cell.
		if (acc.wr && !rst) begin
			case (tgt)
				TGT_TIMER:   timer_d = acc.wdata;
				TGT_PCL: begin
					pcl_d = acc.wdata;
					pcw_d = 1'b1;
					pcv_d = {pch_q, acc.wdata};
				end
				TGT_FLAGS: begin
					// Timeout and powerdown are read-only to the core.
					flags_d[7:5] = acc.wdata[7:5];
					flags_d[2:0] = acc.wdata[2:0];
				end
				TGT_POINTER: ptr_d   = acc.wdata;
				TGT_PORT_A:  port_a_pins_d = acc.wdata[PORT_A_WIDTH-1:0];
				TGT_PORT_B:  port_b_pins_d = acc.wdata;
				TGT_PCH:     pch_d   = acc.wdata[PC_HI_BITS-1:0];
				default:     ;
			endcase
		end
		// An instruction result on the arithmetic flags wins over a write of
		// the flags register, so the ALU outcome is lost only to a reset.
		if (flag_upd.arith_we) begin
			flags_d[FLG_ZERO]  = flag_upd.zero;
			flags_d[FLG_DIGIT] = flag_upd.digit_carry;
			flags_d[FLG_CARRY] = flag_upd.carry;
		end
		if (rst) begin
			pcl_d  = PC_LOW_RST_VAL;
			pch_d  = PC_HI_RST_VAL;
			pcw_d  = 1'b0;
			pcv_d  = 13'h0000;
			port_a_pins_d[PORT_A_WIDTH-2:0] = '0;
			rvalid_d = 1'b0;
			rdata_d  = READ_ZERO;
			if (rst_power_up) begin
				// Undefined cells take zero so simulation starts clean.
				timer_d = UNDEF_POR_VAL;
				ptr_d   = UNDEF_POR_VAL;
				port_b_pins_d = UNDEF_POR_VAL;
				port_a_pins_d = '0;
				flags_d = FLAGS_POR_VAL;
			end else begin
				// Warm reset: timer, pointer, port B and flags 2-0 kept.
				timer_d = timer_q;
				ptr_d   = ptr_q;
				port_b_pins_d = port_b_pins_q;
				flags_d[7:5] = 3'h0;
				if (flag_upd.pwr_we) begin
					flags_d[FLG_TIMEOUT] = flag_upd.timeout;
					flags_d[FLG_PWRDOWN] = flag_upd.powerdown;
				end else begin
					flags_d[FLG_TIMEOUT] = flags_q[FLG_TIMEOUT];
					flags_d[FLG_PWRDOWN] = flags_q[FLG_PWRDOWN];
				end
				flags_d[2:0] = flags_q[2:0];
			end
		end
	end

	// Plain static flops with no refresh.
	always_ff @(posedge mclk) begin
		timer_q  <= timer_d;
		pcl_q    <= pcl_d;
		flags_q  <= flags_d;
		ptr_q    <= ptr_d;
		port_a_pins_q  <= port_a_pins_d;
		port_b_pins_q  <= port_b_pins_d;
		pch_q    <= pch_d;
		rdata_q  <= rdata_d;
		rvalid_q <= rvalid_d;
		pcw_q    <= pcw_d;
		pcv_q    <= pcv_d;
	end

	// RAM keeps its contents through every reset.
	always_ff @(posedge mclk) begin
		if (acc.wr && !rst && tgt == TGT_RAM) begin
			gpr_mem[ram_idx] <= acc.wdata;
		end
	end

	// Shadow of the last RAM write, for the checks only: an indirect read
	// is held against the byte stored, not against the read path itself.
	always_comb begin
		chk_ok_d   = chk_ok_q;
		chk_addr_d = chk_addr_q;
		chk_data_d = chk_data_q;
		if (acc.wr && tgt == TGT_RAM) begin
			chk_ok_d   = 1'b1;
			chk_addr_d = full_addr;
			chk_data_d = acc.wdata;
		end
		if (rst) begin
			chk_ok_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		chk_ok_q   <= chk_ok_d;
		chk_addr_q <= chk_addr_d;
		chk_data_q <= chk_data_d;
	end

	assign rdata         = rdata_q;
	assign rvalid        = rvalid_q;
	assign pc_write      = pcw_q;
	assign pc_load_value = pcv_q;
	assign flags         = flags_q;
	assign port_a_out    = 8'(port_a_pins_q);
	assign port_b_out    = port_b_pins_q;

	// Checks.
	sequence s_write_ptr;
		acc.wr && !rst && acc.addr == OFF_IND_POINTER;
	endsequence

	sequence s_read_ind;
		acc.rd && !rst && acc.addr == OFF_INDIRECT_DATA;
	endsequence

	a_ptr_then_ind: assert property (@(posedge mclk) disable iff (rst)
		s_write_ptr ##1 s_read_ind |=>
		!(($past(acc.wdata, 2) & 8'h7f)
		inside {8'h00, 8'h07, 8'h08, 8'h09}) || rdata == 8'h00)
		else $error("Indirect read through an empty pointer not zero.");

	a_ind_read_ram: assert property (@(posedge mclk) disable iff (rst)
		acc.rd && !acc.wr && is_indirect && chk_ok_q
		&& ptr_q == chk_addr_q |=> rdata == $past(chk_data_q))
		else $error("Indirect read missed the stored byte.");

	a_write_read_back: assert property (@(posedge mclk) disable iff (rst)
		acc.wr && acc.addr == OFF_IND_POINTER ##1 acc.rd
		&& acc.addr == OFF_IND_POINTER && !acc.wr |=>
		rdata == $past(acc.wdata, 2))
		else $error("Pointer write not seen by the next read.");

	a_flags_mirror: assert property (@(posedge mclk) disable iff (rst)
		acc.rd && acc.addr == OFF_CORE_FLAGS |=> rdata == $past(flags_q))
		else $error("Flags read differs between banks.");

	a_gap_reads_zero: assert property (@(posedge mclk) disable iff (rst)
		acc.rd && acc.addr inside {7'h07, 7'h08, 7'h09} |=> rdata == 8'h00)
		else $error("Gap offset did not read zero.");

	a_pch_high_zero: assert property (@(posedge mclk) disable iff (rst)
		acc.rd && acc.addr == OFF_PC_HIGH_LATCH |=> rdata[7:5] == 3'h0)
		else $error("High latch top bits not zero.");

	a_por_flags: assert property (@(posedge mclk)
		rst && rst_power_up |=> flags_q[7:3] == 5'h03)
		else $error("Power-up flags value wrong.");

	a_warm_keep: assert property (@(posedge mclk)
		rst && !rst_power_up |=> timer_q == $past(timer_q)
		&& ptr_q == $past(ptr_q) && port_b_pins_q == $past(port_b_pins_q)
		&& flags_q[7:5] == 3'h0 && flags_q[2:0] == $past(flags_q[2:0]))
		else $error("Warm reset disturbed kept registers.");

	a_pcl_reset: assert property (@(posedge mclk)
		rst |=> pcl_q == 8'h00 && pch_q == 5'h00
		&& port_a_pins_q[PORT_A_WIDTH-2:0] == '0)
		else $error("Reset did not clear counter bytes.");

	a_bank_upper: assert property (@(posedge mclk) disable iff (rst)
		acc.rd && flags_q[FLG_BANK_SEL] && acc.addr == OFF_TIMER_COUNT
		|=> rdata == 8'h00)
		else $error("Upper bank read reached the timer.");

endmodule : bdmm_map

// *** design/bdmm_pkg.sv ***
// Package with offsets, field positions, reset values and carriers for the data map.
package bdmm_pkg;

	// Core register offsets, decoded on the low seven address bits.
	localparam logic [6:0] OFF_INDIRECT_DATA = 7'h00;
	localparam logic [6:0] OFF_TIMER_COUNT   = 7'h01;
	localparam logic [6:0] OFF_PC_LOW_BYTE   = 7'h02;
	localparam logic [6:0] OFF_CORE_FLAGS    = 7'h03;
	localparam logic [6:0] OFF_IND_POINTER   = 7'h04;
	localparam logic [6:0] OFF_PORT_A_PINS   = 7'h05;
	localparam logic [6:0] OFF_PORT_B_PINS   = 7'h06;
	localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0a;

	// General-purpose RAM windows in the full 8-bit data address space.
	localparam logic [7:0] GPR0_FIRST  = 8'h20;
	localparam logic [7:0] GPR0_LAST   = 8'h7f;
	localparam logic [7:0] GPR1_FIRST  = 8'ha0;
	localparam logic [7:0] GPR1_LAST   = 8'hbf;
	localparam logic [7:0] ALIAS_FIRST = 8'hf0;
	localparam logic [7:0] ALIAS_MASK  = 8'h7f;
	localparam logic [6:0] GPR1_BASE   = 7'h60;

	// Field positions in the core flags register.
	localparam int FLG_RSV_IND  = 7;
	localparam int FLG_RSV_HIGH = 6;
	localparam int FLG_BANK_SEL = 5;
	localparam int FLG_TIMEOUT  = 4;
	localparam int FLG_PWRDOWN  = 3;
	localparam int FLG_ZERO     = 2;
	localparam int FLG_DIGIT    = 1;
	localparam int FLG_CARRY    = 0;

	// Reset values; undefined power-up bits are given zero here.
	localparam logic [7:0] FLAGS_POR_VAL  = 8'h18;
	localparam logic [7:0] PC_LOW_RST_VAL = 8'h00;
	localparam logic [4:0] PC_HI_RST_VAL  = 5'h00;
	localparam logic [7:0] UNDEF_POR_VAL  = 8'h00;
	localparam logic [7:0] READ_ZERO      = 8'h00;
	localparam int         PORT_A_BITS    = 5;
	localparam int         PC_HI_BITS     = 5;
	localparam int         GPR_WORDS      = 128;

	// Register targets of one decoded access.
	typedef enum logic [3:0] {
		TGT_NONE,
		TGT_TIMER,
		TGT_PCL,
		TGT_FLAGS,
		TGT_POINTER,
		TGT_PORT_A,
		TGT_PORT_B,
		TGT_PCH,
		TGT_RAM
	} bdmm_target_e;

	// One register access from the core.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bdmm_access_s;

	// Arithmetic and power flag updates from the core.
	typedef struct packed {
		logic arith_we;
		logic zero;
		logic digit_carry;
		logic carry;
		logic pwr_we;
		logic timeout;
		logic powerdown;
	} bdmm_flag_upd_s;

endpackage : bdmm_pkg

// *** verif/bdmm_core_model.sv ***
// Behavioural core datapath that drives accesses into the data map.
`timescale 1ns/1ps
module bdmm_core_model
	import bdmm_pkg::*;
(
	// Clock
	input  wire logic       mclk,
	// Access side
	output bdmm_access_s    acc,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid,
	// Datapath updates
	output bdmm_flag_upd_s  flag_upd,
	output logic            pc_step,
	output logic [7:0]      pc_low_next,
	output logic            timer_tick
);
	initial begin
		acc = '0;
		flag_upd = '0;
		pc_step = 1'b0;
		pc_low_next = 8'h00;
		timer_tick = 1'b0;
	end

	task automatic req(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk);
		#1;
		acc.addr = a[6:0];
		acc.wdata = (a[6:0] == OFF_CORE_FLAGS) ? {2'h0, d[5:0]} : d;
		acc.wr = w;
		acc.rd = !w;
		@(posedge mclk);
		#1;
		acc.wr = 1'b0;
		acc.rd = 1'b0;
		// Released data must not keep looking valid.
		acc.wdata = ~acc.wdata;
	endtask : req

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req(a, d, 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v,
		output logic ok);
		req(a, 8'h00, 1'b0);
		ok = rvalid;
		v = rdata;
	endtask : rd

	// A write followed in the very next cycle by a read.
	task automatic wr_rd(input logic [7:0] aw, input logic [7:0] dw,
		input logic [7:0] ar, output logic [7:0] v, output logic ok);
		@(posedge mclk);
		#1;
		acc.addr = aw[6:0];
		acc.wdata = dw;
		acc.wr = 1'b1;
		acc.rd = 1'b0;
		@(posedge mclk);
		#1;
		acc.addr = ar[6:0];
		acc.wr = 1'b0;
		acc.rd = 1'b1;
		@(posedge mclk);
		#1;
		acc.rd = 1'b0;
		acc.wdata = ~acc.wdata;
		ok = rvalid;
		v = rdata;
	endtask : wr_rd

	// One cycle of timeout and powerdown flag loading.
	task automatic pwr(input logic t, input logic p);
		@(posedge mclk);
		#1;
		flag_upd.pwr_we = 1'b1;
		flag_upd.timeout = t;
		flag_upd.powerdown = p;
		@(posedge mclk);
		#1;
		flag_upd = '0;
	endtask : pwr

	// One datapath cycle: timer tick, zero flag set, program counter load.
	task automatic bump();
		@(posedge mclk);
		#1;
		timer_tick = 1'b1;
		flag_upd.arith_we = 1'b1;
		flag_upd.zero = 1'b1;
		pc_step = 1'b1;
		pc_low_next = 8'h77;
		@(posedge mclk);
		#1;
		timer_tick = 1'b0;
		flag_upd = '0;
		pc_step = 1'b0;
	endtask : bump
endmodule : bdmm_core_model

// *** verif/testbench.sv ***
// Self-checking bench for the banked data map.
`timescale 1ns/1ps
module testbench;
	import bdmm_pkg::*;
	logic           mclk;
	logic           rst;
	logic           rst_power_up;
	bdmm_access_s   acc;
	bdmm_flag_upd_s flag_upd;
	logic [7:0]     rdata, pc_low_next, flags, port_a_out, port_b_out;
	logic           rvalid, pc_step, timer_tick, pc_write;
	logic [12:0]    pc_load_value;
	int             n_mismatch, n_checks;
	logic [7:0]     v, d, a;
	logic           ok;
	logic [7:0]     offs [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0a};

	bdmm_map uut (.mclk(mclk), .rst(rst), .rst_power_up(rst_power_up),
		.acc(acc), .rdata(rdata), .rvalid(rvalid), .flag_upd(flag_upd),
		.pc_step(pc_step), .pc_low_next(pc_low_next),
		.timer_tick(timer_tick), .pc_write(pc_write),
		.pc_load_value(pc_load_value), .flags(flags),
		.port_a_out(port_a_out), .port_b_out(port_b_out));
	bdmm_core_model core (.mclk(mclk), .acc(acc), .rdata(rdata),
		.rvalid(rvalid), .flag_upd(flag_upd), .pc_step(pc_step),
		.pc_low_next(pc_low_next), .timer_tick(timer_tick));

	always #4 mclk = ~mclk;

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	// Readable bits of a core register; missing registers read zero.
	function automatic logic [7:0] reg_mask(input logic [7:0] o);
		if (o == 8'h05 || o == 8'h0a)
			return 8'h1f;
		return (o >= 8'h07 && o <= 8'h09) ? 8'h00 : 8'hff;
	endfunction : reg_mask

	task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
		core.rd(ad, v, ok);
		check(ok, 1'b1);
		check(v, exp);
	endtask : rdc

	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		rst_power_up = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		void'($urandom(58482));
		repeat (20) @(posedge mclk);
		#1 rst = 1'b0;
		check(flags, FLAGS_POR_VAL);
		check(port_a_out[3:0], 4'h0);
		rdc(8'h02, 8'h00);
		rdc(8'h0a, 8'h00);
		foreach (offs[i]) begin
			d = 8'($urandom);
			core.wr(offs[i], d);
			rdc(offs[i], d & reg_mask(offs[i]));
			if (offs[i] == 8'h06)
				check(port_b_out, d);
			if (offs[i] == 8'h05)
				check(port_a_out, {3'h0, d[4:0]});
		end
		repeat (12) begin
			a = 8'h20 + 8'($urandom_range(95));
			d = 8'($urandom);
			core.wr(a, d);
			rdc(a, d);
		end
		d = 8'($urandom);
		core.wr_rd(8'h04, d, 8'h04, v, ok);
		check(ok, 1'b1);
		check(v, d);
		core.wr_rd(8'h04, 8'h88, 8'h00, v, ok);
		check(ok, 1'b1);
		check(v, 8'h00);
		core.wr(8'h04, 8'h40);
		core.wr(8'h00, 8'h5a);
		rdc(8'h40, 8'h5a);
		rdc(8'h00, 8'h5a);
		core.wr(8'h04, 8'ha5);
		core.wr(8'h00, 8'hc3);
		core.wr(8'h03, 8'h20);
		rdc(8'h25, 8'hc3);
		rdc(8'h03, 8'h38);
		rdc(8'h01, 8'h00);
		core.wr(8'h75, 8'h99);
		core.wr(8'h03, 8'h00);
		rdc(8'h75, 8'h99);
		core.wr(8'h0a, 8'h03);
		core.wr(8'h02, 8'h12);
		check(pc_write, 1'b1);
		check(pc_load_value, 13'h0312);
		core.wr(8'h01, 8'h10);
		core.bump();
		rdc(8'h01, 8'h11);
		rdc(8'h03, 8'h1c);
		rdc(8'h02, 8'h77);
		core.pwr(1'b0, 1'b1);
		rdc(8'h03, 8'h0c);
		core.pwr(1'b1, 1'b1);
		rdc(8'h03, 8'h1c);
		core.wr(8'h04, 8'h6b);
		core.wr(8'h06, 8'hc4);
		core.wr(8'h05, 8'h1f);
		core.wr(8'h03, 8'h24);
		@(posedge mclk);
		#1 rst = 1'b1;
		rst_power_up = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		check(flags, 8'h1c);
		check(port_a_out, 8'h10);
		check(port_b_out, 8'hc4);
		rdc(8'h04, 8'h6b);
		rdc(8'h01, 8'h11);
		rdc(8'h02, 8'h00);
		rdc(8'h0a, 8'h00);
		end_sim();
	end
endmodule : testbench
